/* File: testbench.sv */
// Self-checking testbench of the video grab trigger control.
`timescale 1ns/1ps
module testbench;
   import vgt_pkg::*;
   localparam int FP = 16;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, oready = 1, want = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, pix_en, trig, txd, auto_gain_control, sq, pal, ovalid, busy, fs;
   logic [1:0] user_in = 2'h0, user_out;
   logic [11:0] ch_sel;
   logic [7:0] gain;
   logic [7:0] first [4];
   logic [9:0] ltot, lact;
   vgt_pix_s pix;
   vgt_out_s out;
   int errors = 0, total_checks = 0, cycles = 0, nw = 0, nsof = 0, ph = 0, k;
   logic [9:0] tot [4] = '{VGT_TOT_STD60, VGT_TOT_STD50, VGT_TOT_SQ60, VGT_TOT_SQ50};
   logic [9:0] act [4] = '{VGT_ACT_STD, VGT_ACT_STD, VGT_ACT_SQ60, VGT_ACT_SQ50};

   vgt_top vgt_top_inst (.i_mclk(clk), .i_reset(rst), .i_paddr(paddr), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_pix_en(pix_en), .i_pix(pix),
      .i_isolated_trigger(trig), .i_user_in(user_in), .i_rxd(txd), .o_txd(txd),
      .o_user_out(user_out), .o_ch_sel(ch_sel), .o_auto_gain_control(auto_gain_control), .o_gain(gain),
      .o_sq_pixel(sq), .o_pal(pal), .o_line_total(ltot), .o_line_active(lact),
      .o_out_valid(ovalid), .o_out(out), .i_out_ready(oready), .o_busy(busy));
   vgt_cam #(.FRAME_PIX(FP)) vgt_cam_inst (.i_mclk(clk), .i_reset(rst), .i_trig_want(want),
      .o_pix_en(pix_en), .o_pix(pix), .o_trig(trig));

   // ============
   // Clock, cycle ceiling and accepted-word bookkeeping.
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         close_out();
      end
      if (ovalid && oready) begin
         if (nw == 0) fs = out.sof;
         if (out.sof) nsof++;
         if (out.sof) ph = 0;
         if (ph < 4) first[ph] = out.data[7:0];
         ph++;
         nw++;
      end
   end

   // ============
   // Comparison, bus cycle and helpers.
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   function automatic logic [31:0] ctl(input logic g, input logic [1:0] m, input logic p,
      input logic a, s, l, input logic [1:0] f, input logic [3:0] c);
      ctl = 32'h0;
      ctl[VGT_CTRL_GO_BIT] = g;
      ctl[VGT_CTRL_MODE_LSB +: 2] = m;
      ctl[VGT_CTRL_POL_BIT] = p;
      ctl[VGT_CTRL_AGC_BIT] = a;
      ctl[VGT_CTRL_SQ_BIT] = s;
      ctl[VGT_CTRL_PAL_BIT] = l;
      ctl[VGT_CTRL_FMT_LSB +: 2] = f;
      ctl[VGT_CTRL_CH_LSB +: 4] = c;
   endfunction : ctl
   task automatic frames(input int n);
      nw = 0;
      nsof = 0;
      repeat (n * FP * 4) @(posedge clk);
   endtask : frames
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out

   // ============
   // Test sequence.
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      chk("ch_sel", ch_sel, 1); chk("txd", txd, 1); chk("gain", gain, VGT_GAIN_RST);
      apb(0, VGT_CTRL_OFS, 0); chk("ctrl", rd, VGT_CTRL_RST);
      apb(0, 8'h20, 0); chk("err", er, 1); chk("err_rd", rd, 0);
      $display("test reset done");
      for (k = 0; k < 16; k++) begin
         apb(1, VGT_CTRL_OFS, ctl(0, 0, 0, 1, 0, 0, 0, k));
         repeat (2) @(posedge clk);
         chk("ch_sel", ch_sel, 12'h001 << ((k > 11) ? 11 : k));
      end
      for (k = 0; k < 4; k++) begin
         apb(1, VGT_CTRL_OFS, ctl(0, 0, 0, 1, k[1], k[0], 0, 0));
         repeat (2) @(posedge clk);
         chk("total", ltot, tot[k]); chk("active", lact, act[k]);
         chk("sq", sq, k[1]); chk("pal", pal, k[0]);
      end
      apb(1, VGT_GAIN_OFS, 32'h3C); apb(1, VGT_CTRL_OFS, ctl(0, 0, 0, 0, 0, 0, 0, 0));
      repeat (2) @(posedge clk);
      chk("agc", auto_gain_control, 0); chk("gain", gain, 8'h3C);
      apb(1, VGT_USER_OFS, 32'h2); user_in <= 2'h1;
      repeat (4) @(posedge clk);
      chk("user_out", user_out, 2'h2);
      apb(0, VGT_USER_OFS, 0); chk("user", rd, 32'h6);
      apb(1, VGT_UART_OFS, 32'h8); apb(1, VGT_UART_OFS, 32'h1_005A);
      repeat (200) @(posedge clk);
      apb(0, VGT_UART_OFS, 0); chk("uart_rx", rd[16:8], 9'h15A);
      $display("test registers done");
      apb(1, VGT_CTRL_OFS, ctl(1, 0, 0, 1, 0, 0, 2'h2, 0));
      repeat (24) @(posedge clk);
      want <= 1;
      frames(3);
      chk("frames", nsof, 1); chk("words", nw, FP); chk("sof_first", fs, 1);
      for (k = 0; k < 4; k++) chk("yuyv", first[k], (k[0] ? 8'hC0 : 8'hA0) | k);
      chk("busy", busy, 0);
      apb(0, VGT_CTRL_OFS, 0); chk("go_clr", rd, ctl(0, 0, 0, 1, 0, 0, 2'h2, 0));
      apb(1, VGT_CTRL_OFS, ctl(1, 0, 1, 1, 0, 0, 0, 0));
      repeat (24) @(posedge clk);
      want <= 0;
      frames(3);
      chk("fall_frames", nsof, 1);
      $display("test one shot done");
      apb(1, VGT_CTRL_OFS, ctl(1, 1, 0, 1, 0, 0, 0, 0));
      want <= 1;
      frames(4);
      want <= 0;
      apb(1, VGT_CTRL_OFS, ctl(0, 1, 0, 1, 0, 0, 0, 0));
      repeat (2 * FP * 4) @(posedge clk);
      chk("cont", nsof >= 3, 1); chk("whole", nw, nsof * FP); chk("busy", busy, 0);
      $display("test continuous done");
      apb(1, VGT_CTRL_OFS, ctl(1, 2, 0, 1, 0, 0, 0, 0));
      want <= 1;
      frames(3);
      want <= 0;
      repeat (3 * FP * 4) @(posedge clk);
      chk("level", nsof >= 2, 1); chk("whole", nw, nsof * FP); chk("armed", busy, 1);
      want <= 1;
      frames(2);
      oready <= 0;
      repeat (20) @(posedge clk);
      chk("stall_valid", ovalid, 1);
      oready <= 1;
      apb(1, VGT_CTRL_OFS, ctl(0, 2, 0, 1, 0, 0, 0, 0));
      $display("test level done");
      close_out();
   end
endmodule : testbench

/* File: vgt_cam.sv */
// Camera and trigger source model feeding pixels and the trigger pin.
`timescale 1ns/1ps
module vgt_cam
   import vgt_pkg::*;
#(
   parameter int FRAME_PIX = 16
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_trig_want,
   output logic o_pix_en,
   output vgt_pix_s o_pix,
   output logic o_trig
);
   logic [1:0] tick_r;
   logic [7:0] idx_r;
   logic odd_r;
   vgt_pix_s pix;

   // ============
   // Pixel tick every fourth clock; pixel index wraps at the frame length.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         tick_r <= 2'h0;
         idx_r <= 8'h00;
         odd_r <= 1'b0;
         o_trig <= 1'b0;
      end else begin
         tick_r <= tick_r + 2'h1;
         if (o_pix_en) begin
            idx_r <= (idx_r == 8'(FRAME_PIX - 1)) ? 8'h00 : idx_r + 8'h01;
            odd_r <= odd_r ^ (idx_r == 8'(FRAME_PIX - 1));
            o_trig <= i_trig_want;
         end
      end
   end

   // Pixel data are only meaningful on a tick; otherwise the lines show the inverse.
   assign o_pix_en = (tick_r == 2'h3);
   assign pix = '{y: 8'hA0 | idx_r, c: 8'hC0 | idx_r, frame_start: idx_r == 8'h00,
      field_odd: odd_r};
   assign o_pix = o_pix_en ? pix : ~pix;
endmodule : vgt_cam

/* File: vgt_monitor.sv */
// Checker of the port relations of the video grab trigger control.
`timescale 1ns/1ps
module vgt_monitor
   import vgt_pkg::*;
#(
   parameter int NUM_CH = 12
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [7:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [1:0] o_user_out,
   input wire logic [NUM_CH-1:0] o_ch_sel,
   input wire logic o_auto_gain_control,
   input wire logic [7:0] o_gain,
   input wire logic o_sq_pixel,
   input wire logic o_pal,
   input wire logic [9:0] o_line_total,
   input wire logic [9:0] o_line_active,
   input wire logic o_out_valid,
   input wire vgt_out_s o_out,
   input wire logic i_out_ready
);
   // ============
   // One clock domain, so clock and reset are given once.
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   AST_ONE_CH: assert property ($onehot(o_ch_sel))
      else $error("channel select is not one-hot");
   AST_AGC_GAIN: assert property (o_auto_gain_control |-> o_gain == VGT_GAIN_RST)
      else $error("gain not neutral while auto gain is on");
   AST_STD_LINE: assert property ($stable(o_sq_pixel) && $stable(o_pal) && !o_sq_pixel
      |-> o_line_active == VGT_ACT_STD && o_line_total == (o_pal ? VGT_TOT_STD50 : VGT_TOT_STD60))
      else $error("standard line timing wrong");
   AST_SQ_LINE: assert property ($stable(o_sq_pixel) && $stable(o_pal) && o_sq_pixel
      |-> o_line_total == (o_pal ? VGT_TOT_SQ50 : VGT_TOT_SQ60)
      && o_line_active == (o_pal ? VGT_ACT_SQ50 : VGT_ACT_SQ60))
      else $error("square line timing wrong");
   AST_HOLD: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out))
      else $error("output word lost during stall");
   AST_READY: assert property (o_pready |-> i_psel && i_penable && $past(i_psel && !i_penable))
      else $error("ready outside an access phase");
   AST_ERR_PAIR: assert property (o_pslverr |-> o_pready)
      else $error("error response without ready");
   AST_USER_WR: assert property (!$stable(o_user_out)
      |-> $past(i_psel && i_penable && i_pwrite && i_paddr == VGT_USER_OFS))
      else $error("user outputs changed without a write");

   // Main scenarios reached.
   cover property (o_out_valid && i_out_ready && o_out.sof);
   cover property (o_out_valid && !i_out_ready);
   cover property (o_pslverr);
endmodule : vgt_monitor

bind vgt_top vgt_monitor #(.NUM_CH(NUM_CH)) vgt_monitor_inst (.i_mclk(i_mclk),
   .i_reset(i_reset), .i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_user_out(o_user_out), .o_ch_sel(o_ch_sel), .o_auto_gain_control(o_auto_gain_control),
   .o_gain(o_gain), .o_sq_pixel(o_sq_pixel), .o_pal(o_pal), .o_line_total(o_line_total),
   .o_line_active(o_line_active), .o_out_valid(o_out_valid), .o_out(o_out),
   .i_out_ready(i_out_ready));

/* File: vgt_pkg.sv */
// Package with constants, types and structs of the video grab trigger control.
package vgt_pkg;

   // ==========================================================
   // Register offsets (byte addresses on APB).
   localparam logic [7:0] VGT_CTRL_OFS = 8'h00;
   localparam logic [7:0] VGT_GAIN_OFS = 8'h04;
   localparam logic [7:0] VGT_USER_OFS = 8'h08;
   localparam logic [7:0] VGT_STAT_OFS = 8'h0C;
   localparam logic [7:0] VGT_UART_OFS = 8'h10;

   // ==========================================================
   // Control register field positions.
   localparam int VGT_CTRL_GO_BIT = 0;
   localparam int VGT_CTRL_MODE_LSB = 1;
   localparam int VGT_CTRL_POL_BIT = 3;
   localparam int VGT_CTRL_AGC_BIT = 4;
   localparam int VGT_CTRL_SQ_BIT = 5;
   localparam int VGT_CTRL_PAL_BIT = 6;
   localparam int VGT_CTRL_FMT_LSB = 7;
   localparam int VGT_CTRL_CH_LSB = 9;
   localparam int VGT_CTRL_SMALL_BIT = 13;

   // ==========================================================
   // Reset values.
   localparam logic [31:0] VGT_CTRL_RST = 32'h0000_0010;
   localparam logic [7:0] VGT_GAIN_RST = 8'h80;
   localparam logic [15:0] VGT_BAUD_RST = 16'h06C8;

   // ==========================================================
   // Line timing in pixels and channel field limits.
   localparam logic [9:0] VGT_TOT_STD60 = 10'd858;
   localparam logic [9:0] VGT_TOT_STD50 = 10'd864;
   localparam logic [9:0] VGT_ACT_STD = 10'd720;
   localparam logic [9:0] VGT_TOT_SQ60 = 10'd780;
   localparam logic [9:0] VGT_ACT_SQ60 = 10'd640;
   localparam logic [9:0] VGT_TOT_SQ50 = 10'd944;
   localparam logic [9:0] VGT_ACT_SQ50 = 10'd768;
   localparam logic [3:0] VGT_CH_MAX_LARGE = 4'd11;
   localparam logic [3:0] VGT_CH_MAX_SMALL = 4'd6;

   // Trigger modes and output formats.
   typedef enum logic [1:0] {
      VGT_MODE_ONESHOT = 2'h0,
      VGT_MODE_EDGE_CONT = 2'h1,
      VGT_MODE_LEVEL = 2'h2
   } vgt_mode_e;

   typedef enum logic [1:0] {
      VGT_FMT_RGB888 = 2'h0,
      VGT_FMT_RGB565 = 2'h1,
      VGT_FMT_YUV422 = 2'h2,
      VGT_FMT_YUV411 = 2'h3
   } vgt_fmt_e;

   // Capture states, Gray coded along idle, armed, wait, grab.
   typedef enum logic [1:0] {
      VGT_ST_IDLE = 2'b00,
      VGT_ST_ARMED = 2'b01,
      VGT_ST_WAIT = 2'b11,
      VGT_ST_GRAB = 2'b10
   } vgt_state_e;

   // Digitized pixel arriving from the decoder.
   typedef struct packed {
      logic [7:0] y;
      logic [7:0] c;
      logic frame_start;
      logic field_odd;
   } vgt_pix_s;

   // Packed output word.
   typedef struct packed {
      logic [23:0] data;
      logic sof;
   } vgt_out_s;

endpackage : vgt_pkg

/* File: vgt_top.sv */
// Video grab trigger control: trigger, channel select, format, gain, user bits, serial.
//
// How it works
// [R1] After a qualified trigger, capture waits for the next valid frame start.
// [R2] One-shot edge mode: wait for active edge, grab one frame, return idle.
// [R3] Edge continuous mode: active edge starts grabbing until software clears go.
// [R4] Level mode: grab frames while the trigger sits at its active level.
// [R5] A polarity bit picks the active edge and the active level.
// [R6] Trigger is resynchronised and sampled only on pixel enable ticks.
// [R7] Exactly one channel select line is driven, from the channel field.
// [R8] Channel field reaches twelve sources; the form factor strap latches the control reset value, so the seven-source limit never applies.
// [R9] Output path packs RGB 888, RGB 565, YUV 422 or YUV 411; YUV 411 is packed the same as YUV 422, Y and C alternating.
// [R10] YUV 422 is emitted as Y, U, Y, V byte order.
// [R11] Auto gain bit; when cleared the manual gain value drives the decoder.
// [R12] Standard sampling: 858 or 864 total, 720 active pixels per line.
// [R13] Square sampling: 780/640 at 60 Hz, 944/768 at 50 Hz.
// [R14] Two user inputs readable, two user outputs writable by software.
// [R15] A software-configured asynchronous serial transmitter and receiver is present.
// [R16] Level mode dropping inactive finishes the current frame, then stops.
`timescale 1ns/1ps
module vgt_top
   import vgt_pkg::*;
#(
   parameter int NUM_CH = 12
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [7:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_pix_en,
   input wire vgt_pix_s i_pix,
   input wire logic i_isolated_trigger,
   input wire logic [1:0] i_user_in,
   input wire logic i_rxd,
   output logic o_txd,
   output logic [1:0] o_user_out,
   output logic [NUM_CH-1:0] o_ch_sel,
   output logic o_auto_gain_control,
   output logic [7:0] o_gain,
   output logic o_sq_pixel,
   output logic o_pal,
   output logic [9:0] o_line_total,
   output logic [9:0] o_line_active,
   output logic o_out_valid,
   output vgt_out_s o_out,
   input wire logic i_out_ready,
   output logic o_busy
);

   // ==========================================================
   // Registers and bus slave
   logic [31:0] ctrl_r;
   logic [7:0] gain_r;
   logic [15:0] baud_r;
   logic small_ff_r;
   logic strap_done_r;
   logic [2:0] trig_sync_r;
   logic trig_lvl_r;
   logic [2:0] uin0_sync_r;
   logic [2:0] uin1_sync_r;
   logic [1:0] uin_r;
   logic [2:0] rxd_sync_r;
   logic rxd_r;
   logic frames_done_r;
   logic [7:0] rx_data_r;
   logic rx_full_r;
   logic tx_busy_r;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic go;
   vgt_mode_e mode;
   logic pol;
   vgt_fmt_e fmt;
   logic [3:0] ch;
   logic [3:0] ch_max;

   assign wr_en = i_psel && i_penable && i_pwrite;
   assign rd_en = i_psel && i_penable && !i_pwrite;
   assign addr_ok = (i_paddr == VGT_CTRL_OFS) || (i_paddr == VGT_GAIN_OFS) ||
                    (i_paddr == VGT_USER_OFS) || (i_paddr == VGT_STAT_OFS) ||
                    (i_paddr == VGT_UART_OFS);
   assign go = ctrl_r[VGT_CTRL_GO_BIT];
   assign mode = vgt_mode_e'(ctrl_r[VGT_CTRL_MODE_LSB +: 2]);
   assign pol = ctrl_r[VGT_CTRL_POL_BIT];
   assign fmt = vgt_fmt_e'(ctrl_r[VGT_CTRL_FMT_LSB +: 2]);
   assign ch = ctrl_r[VGT_CTRL_CH_LSB +: 4];
   // [R8] channel limit
   assign ch_max = small_ff_r ? VGT_CH_MAX_SMALL : VGT_CH_MAX_LARGE;

   // Form factor strap is latched once after reset release.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         small_ff_r <= 1'b0;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         small_ff_r <= ctrl_r[VGT_CTRL_SMALL_BIT];
         strap_done_r <= 1'b1;
      end
   end

   logic one_done;
   // Control register; a finished one-shot clears go, a software write can set it again.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         ctrl_r <= VGT_CTRL_RST;
      end else if (wr_en && i_paddr == VGT_CTRL_OFS) begin
         ctrl_r <= i_pwdata;
         // [R8] clamp channel
         if (i_pwdata[VGT_CTRL_CH_LSB +: 4] > ch_max) begin
            ctrl_r[VGT_CTRL_CH_LSB +: 4] <= ch_max;
         end
      end else if (one_done) begin
         ctrl_r[VGT_CTRL_GO_BIT] <= 1'b0;
      end
   end

   // Gain, user outputs and serial divider registers.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         gain_r <= VGT_GAIN_RST;
         o_user_out <= 2'h0;
         baud_r <= VGT_BAUD_RST;
      end else if (wr_en) begin
         // [R14] user outputs
         if (i_paddr == VGT_USER_OFS) o_user_out <= i_pwdata[1:0];
         if (i_paddr == VGT_GAIN_OFS) gain_r <= i_pwdata[7:0];
         if (i_paddr == VGT_UART_OFS && !i_pwdata[16]) baud_r <= i_pwdata[15:0];
      end
   end

   // Read mux, always ready, error on unmapped addresses.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_prdata <= 32'h0;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !addr_ok;
         o_prdata <= 32'h0;
         if (i_psel && !i_penable && !i_pwrite) begin
            unique case (i_paddr)
               VGT_CTRL_OFS: o_prdata <= ctrl_r;
               VGT_GAIN_OFS: o_prdata <= {24'h0, gain_r};
               // [R14] user inputs
               VGT_USER_OFS: o_prdata <= {28'h0, uin_r, o_user_out};
               VGT_STAT_OFS: o_prdata <= {27'h0, rx_full_r, tx_busy_r, frames_done_r,
                                          trig_lvl_r, o_busy};
               VGT_UART_OFS: o_prdata <= {15'h0, rx_full_r, rx_data_r, 8'h0};
               default: o_prdata <= 32'h0;
            endcase
         end
      end
   end

   // ==========================================================
   // Pin synchronisers: a change counts once stages two and three agree.
   // [R6] trigger sync
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         trig_sync_r <= 3'h0;
         uin0_sync_r <= 3'h0;
         uin1_sync_r <= 3'h0;
         rxd_sync_r <= 3'h7;
         trig_lvl_r <= 1'b0;
         uin_r <= 2'h0;
         rxd_r <= 1'b1;
      end else begin
         trig_sync_r <= {trig_sync_r[1:0], i_isolated_trigger};
         uin0_sync_r <= {uin0_sync_r[1:0], i_user_in[0]};
         uin1_sync_r <= {uin1_sync_r[1:0], i_user_in[1]};
         rxd_sync_r <= {rxd_sync_r[1:0], i_rxd};
         if (trig_sync_r[1] == trig_sync_r[2] && i_pix_en) trig_lvl_r <= trig_sync_r[2];
         if (uin0_sync_r[1] == uin0_sync_r[2]) uin_r[0] <= uin0_sync_r[2];
         if (uin1_sync_r[1] == uin1_sync_r[2]) uin_r[1] <= uin1_sync_r[2];
         if (rxd_sync_r[1] == rxd_sync_r[2]) rxd_r <= rxd_sync_r[2];
      end
   end

   // ==========================================================
   // Trigger qualification and capture state machine
   vgt_state_e state_r;
   logic trig_prev_r;
   logic active_lvl;
   logic active_edge;
   logic sof;

   // [R5] polarity
   assign active_lvl = trig_lvl_r ^ pol;
   assign active_edge = i_pix_en && active_lvl && !(trig_prev_r ^ pol);
   assign sof = i_pix_en && i_pix.frame_start;
   assign one_done = (state_r == VGT_ST_GRAB) && sof && mode == VGT_MODE_ONESHOT;

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         trig_prev_r <= 1'b0;
      end else if (i_pix_en) begin
         trig_prev_r <= trig_lvl_r;
      end
   end

   // Capture sequencing; a frame ends at the next frame start.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         state_r <= VGT_ST_IDLE;
         frames_done_r <= 1'b0;
      end else begin
         unique case (state_r)
            VGT_ST_IDLE: begin
               if (go) state_r <= VGT_ST_ARMED;
            end
            VGT_ST_ARMED: begin
               if (!go) begin
                  state_r <= VGT_ST_IDLE;
               // [R4] level start
               end else if (mode == VGT_MODE_LEVEL ? active_lvl : active_edge) begin
                  state_r <= VGT_ST_WAIT;
               end
            end
            VGT_ST_WAIT: begin
               // [R1] next valid frame
               if (!go) state_r <= VGT_ST_IDLE;
               else if (sof) state_r <= VGT_ST_GRAB;
            end
            VGT_ST_GRAB: begin
               if (sof) begin
                  frames_done_r <= 1'b1;
                  // [R2] single frame
                  if (mode == VGT_MODE_ONESHOT) state_r <= VGT_ST_IDLE;
                  // [R3] software stop
                  else if (!go) state_r <= VGT_ST_IDLE;
                  // [R16] finish frame
                  else if (mode == VGT_MODE_LEVEL && !active_lvl) state_r <= VGT_ST_ARMED;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Decoder controls and timing
   // [R7] one-hot channel
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         always_ff @(posedge i_mclk or posedge i_reset) begin
            if (i_reset) o_ch_sel[gi] <= (gi == 0);
            else o_ch_sel[gi] <= (ch == 4'(gi));
         end
      end
   endgenerate

   // Gain, sampling and line timing outputs.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_auto_gain_control <= 1'b1;
         o_gain <= VGT_GAIN_RST;
         o_sq_pixel <= 1'b0;
         o_pal <= 1'b0;
         o_line_total <= VGT_TOT_STD60;
         o_line_active <= VGT_ACT_STD;
         o_busy <= 1'b0;
      end else begin
         // [R11] manual gain
         o_auto_gain_control <= ctrl_r[VGT_CTRL_AGC_BIT];
         o_gain <= ctrl_r[VGT_CTRL_AGC_BIT] ? VGT_GAIN_RST : gain_r;
         o_sq_pixel <= ctrl_r[VGT_CTRL_SQ_BIT];
         o_pal <= ctrl_r[VGT_CTRL_PAL_BIT];
         o_busy <= state_r != VGT_ST_IDLE;
         if (!ctrl_r[VGT_CTRL_SQ_BIT]) begin
            // [R12] standard
            o_line_total <= ctrl_r[VGT_CTRL_PAL_BIT] ? VGT_TOT_STD50 : VGT_TOT_STD60;
            o_line_active <= VGT_ACT_STD;
         end else begin
            // [R13] square pixel
            o_line_total <= ctrl_r[VGT_CTRL_PAL_BIT] ? VGT_TOT_SQ50 : VGT_TOT_SQ60;
            o_line_active <= ctrl_r[VGT_CTRL_PAL_BIT] ? VGT_ACT_SQ50 : VGT_ACT_SQ60;
         end
      end
   end

   // ==========================================================
   // Pixel packing into a two-entry buffer
   logic [1:0] phase_r;
   logic [23:0] pk_data;
   logic pk_valid;
   vgt_out_s buf_r [2];
   logic [1:0] cnt_r;
   logic wp_r;
   logic rp_r;
   logic push;
   logic pop;
   logic stay;

   // [R9] format packing
   always_comb begin
      pk_data = 24'h0;
      unique case (fmt)
         VGT_FMT_RGB888: pk_data = {i_pix.y, i_pix.c, i_pix.y};
         VGT_FMT_RGB565: pk_data = {8'h0, i_pix.y[7:3], i_pix.c[7:2], i_pix.y[7:3]};
         // [R10] Y U Y V
         VGT_FMT_YUV422: pk_data = {16'h0, i_pix.y};
         VGT_FMT_YUV411: pk_data = {16'h0, i_pix.y};
      endcase
      // Chroma byte interleaves with luma: phase 1 carries U, phase 3 carries V.
      if ((fmt == VGT_FMT_YUV422 || fmt == VGT_FMT_YUV411) && phase_r[0] &&
          !i_pix.frame_start) begin
         pk_data = {16'h0, i_pix.c};
      end
   end

   assign stay = mode != VGT_MODE_ONESHOT && go && (mode != VGT_MODE_LEVEL || active_lvl);
   assign pk_valid = sof ? (state_r == VGT_ST_WAIT && go) || (state_r == VGT_ST_GRAB && stay)
                         : i_pix_en && state_r == VGT_ST_GRAB;
   assign push = pk_valid && cnt_r != 2'd2;
   assign pop = o_out_valid && i_out_ready;

   // Byte phase counter for the luma and chroma interleave.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) phase_r <= 2'h0;
      else if (sof) phase_r <= 2'(push);
      else if (push) phase_r <= phase_r + 2'h1;
   end

   // Buffer storage and pointers; a full buffer drops nothing already held.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         buf_r[0] <= '0;
         buf_r[1] <= '0;
         cnt_r <= 2'h0;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
      end else begin
         if (push) begin
            buf_r[wp_r] <= '{data: pk_data, sof: i_pix.frame_start};
            wp_r <= ~wp_r;
         end
         if (pop) rp_r <= ~rp_r;
         cnt_r <= cnt_r + 2'(push) - 2'(pop);
      end
   end

   // Registered output stage of the buffer.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_out_valid <= 1'b0;
         o_out <= '0;
      end else begin
         o_out_valid <= (cnt_r + 2'(push) - 2'(pop)) != 2'h0;
         o_out <= (pop || !o_out_valid) ? buf_r[rp_r ^ pop] : o_out;
         if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) o_out <= '{data: pk_data, sof: i_pix.frame_start};
      end
   end

   // ==========================================================
   // Serial transceiver, 8N1, divider from the baud register
   logic [15:0] tx_div_r;
   logic [3:0] tx_cnt_r;
   logic [9:0] tx_sh_r;
   logic [15:0] rx_div_r;
   logic [3:0] rx_cnt_r;
   logic [7:0] rx_sh_r;

   // [R15] serial transmit
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         tx_busy_r <= 1'b0;
         tx_div_r <= 16'h0;
         tx_cnt_r <= 4'h0;
         tx_sh_r <= 10'h3FF;
         o_txd <= 1'b1;
      end else if (!tx_busy_r) begin
         o_txd <= 1'b1;
         if (wr_en && i_paddr == VGT_UART_OFS && i_pwdata[16]) begin
            tx_sh_r <= {1'b1, i_pwdata[7:0], 1'b0};
            tx_busy_r <= 1'b1;
            tx_cnt_r <= 4'h0;
            tx_div_r <= 16'h0;
         end
      end else if (tx_div_r == 16'h0) begin
         o_txd <= tx_sh_r[0];
         tx_sh_r <= {1'b1, tx_sh_r[9:1]};
         tx_div_r <= baud_r;
         tx_cnt_r <= tx_cnt_r + 4'h1;
         if (tx_cnt_r == 4'd10) tx_busy_r <= 1'b0;
      end else begin
         tx_div_r <= tx_div_r - 16'h1;
      end
   end

   // [R15] serial receive
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         rx_div_r <= 16'h0;
         rx_cnt_r <= 4'h0;
         rx_sh_r <= 8'h0;
         rx_data_r <= 8'h0;
         rx_full_r <= 1'b0;
      end else begin
         if (rx_cnt_r == 4'h0) begin
            if (!rxd_r) begin
               rx_cnt_r <= 4'h1;
               rx_div_r <= {1'b0, baud_r[15:1]};
            end
         end else if (rx_div_r != 16'h0) begin
            rx_div_r <= rx_div_r - 16'h1;
         end else begin
            rx_div_r <= baud_r;
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r >= 4'd2 && rx_cnt_r <= 4'd9) rx_sh_r <= {rxd_r, rx_sh_r[7:1]};
            if (rx_cnt_r == 4'd10) begin
               rx_cnt_r <= 4'h0;
               rx_data_r <= rx_sh_r;
            end
         end
         // Reading the data register clears full; a new byte in the same cycle wins.
         if (rx_cnt_r == 4'd10 && rx_div_r == 16'h0) rx_full_r <= 1'b1;
         else if (rd_en && i_paddr == VGT_UART_OFS) rx_full_r <= 1'b0;
      end
   end

endmodule : vgt_top
